// ==== hw/dual_tap_map.svh ====
`ifndef DUAL_TAP_MAP_SVH
`define DUAL_TAP_MAP_SVH

`define IR_WIDTH          4
`define IR_RESET_VALUE    4'h1
`define IR_CAPTURE_VALUE  4'h1
`define IR_BYPASS         4'hf
`define IR_IDCODE         4'h1
`define IR_BSCAN          4'h2
`define IR_DEBUG_DATA     4'h8
`define DEBUG_DR_WIDTH    32
`define BSCAN_WIDTH       16
`define IDCODE_VALUE      32'h1234_5671

`endif

// ==== hw/dual_tap_pkg.sv ====
package dual_tap_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_type;

    typedef struct packed {
        logic mode_select;
        logic data_in;
    } tap_in_type;

    typedef struct packed {
        logic shift_out;
        logic out_enable;
    } tap_out_type;

    typedef struct packed {
        logic [1:0] core_req;
        logic [1:0] core_ack;
    } sync_type;

endpackage

// ==== hw/tap_controller.sv ====
`timescale 1ns/100ps
`include "dual_tap_map.svh"

module tap_controller #(
    parameter logic [31:0] ID_VALUE = `IDCODE_VALUE
) (
    input  wire logic                        tck_in,
    input  wire logic                        trst_n_in,
    input  wire dual_tap_pkg::tap_in_type    tap_in,
    input  wire logic [`BSCAN_WIDTH-1:0]     bscan_capture_in,
    input  wire logic [`DEBUG_DR_WIDTH-1:0]  debug_capture_in,
    output dual_tap_pkg::tap_out_type        tap_out,
    output logic [`BSCAN_WIDTH-1:0]          bscan_update_out,
    output logic [`DEBUG_DR_WIDTH-1:0]       debug_update_out,
    output logic                             debug_update_pulse_out
);
    typedef struct packed {
        dual_tap_pkg::tap_state_type state;
        logic [`IR_WIDTH-1:0]        ir_shift;
        logic [`IR_WIDTH-1:0]        ir;
        logic [`DEBUG_DR_WIDTH-1:0]  dr_shift;
        logic [`BSCAN_WIDTH-1:0]     bscan_upd;
        logic [`DEBUG_DR_WIDTH-1:0]  debug_upd;
        logic                        debug_pulse;
    } rise_state_type;

    rise_state_type st_r;
    rise_state_type st_nxt;
    dual_tap_pkg::tap_out_type out_r;
    dual_tap_pkg::tap_out_type out_nxt;

    function automatic logic [5:0] dr_len(input logic [`IR_WIDTH-1:0] ir);
        case (ir)
            `IR_IDCODE:     dr_len = 6'd32;
            `IR_BSCAN:      dr_len = 6'd16;
            `IR_DEBUG_DATA: dr_len = 6'd32;
            default:        dr_len = 6'd1;
        endcase
    endfunction

    function automatic dual_tap_pkg::tap_state_type next_state(
        input dual_tap_pkg::tap_state_type s, input logic m);
        case (s)
            dual_tap_pkg::TEST_LOGIC_RESET: next_state = m ? s : dual_tap_pkg::RUN_TEST_IDLE;
            dual_tap_pkg::RUN_TEST_IDLE:    next_state = m ? dual_tap_pkg::SELECT_DR : s;
            dual_tap_pkg::SELECT_DR:   next_state = m ? dual_tap_pkg::SELECT_IR : dual_tap_pkg::CAPTURE_DR;
            dual_tap_pkg::CAPTURE_DR:  next_state = m ? dual_tap_pkg::EXIT1_DR : dual_tap_pkg::SHIFT_DR;
            dual_tap_pkg::SHIFT_DR:    next_state = m ? dual_tap_pkg::EXIT1_DR : s;
            dual_tap_pkg::EXIT1_DR:    next_state = m ? dual_tap_pkg::UPDATE_DR : dual_tap_pkg::PAUSE_DR;
            dual_tap_pkg::PAUSE_DR:    next_state = m ? dual_tap_pkg::EXIT2_DR : s;
            dual_tap_pkg::EXIT2_DR:    next_state = m ? dual_tap_pkg::UPDATE_DR : dual_tap_pkg::SHIFT_DR;
            dual_tap_pkg::UPDATE_DR:   next_state = m ? dual_tap_pkg::SELECT_DR : dual_tap_pkg::RUN_TEST_IDLE;
            dual_tap_pkg::SELECT_IR:   next_state = m ? dual_tap_pkg::TEST_LOGIC_RESET : dual_tap_pkg::CAPTURE_IR;
            dual_tap_pkg::CAPTURE_IR:  next_state = m ? dual_tap_pkg::EXIT1_IR : dual_tap_pkg::SHIFT_IR;
            dual_tap_pkg::SHIFT_IR:    next_state = m ? dual_tap_pkg::EXIT1_IR : s;
            dual_tap_pkg::EXIT1_IR:    next_state = m ? dual_tap_pkg::UPDATE_IR : dual_tap_pkg::PAUSE_IR;
            dual_tap_pkg::PAUSE_IR:    next_state = m ? dual_tap_pkg::EXIT2_IR : s;
            dual_tap_pkg::EXIT2_IR:    next_state = m ? dual_tap_pkg::UPDATE_IR : dual_tap_pkg::SHIFT_IR;
            dual_tap_pkg::UPDATE_IR:   next_state = m ? dual_tap_pkg::SELECT_DR : dual_tap_pkg::RUN_TEST_IDLE;
            default:                   next_state = dual_tap_pkg::TEST_LOGIC_RESET;
        endcase
    endfunction

    logic [5:0] len;
    assign len = dr_len(st_r.ir);

    always_comb begin
        st_nxt             = st_r;
        st_nxt.debug_pulse = 1'b0;
        st_nxt.state       = next_state(st_r.state, tap_in.mode_select);
        // flag stands through update-dr so the edge that leaves it also moves the
        // toggle; the prober may stop the test clock right after that edge
        st_nxt.debug_pulse = (st_nxt.state == dual_tap_pkg::UPDATE_DR)
                          && (st_r.ir == `IR_DEBUG_DATA);
        case (st_r.state)
            dual_tap_pkg::TEST_LOGIC_RESET: begin
                st_nxt.ir = `IR_RESET_VALUE;
            end
            dual_tap_pkg::CAPTURE_IR: begin
                st_nxt.ir_shift = `IR_CAPTURE_VALUE;
            end
            dual_tap_pkg::SHIFT_IR: begin
                st_nxt.ir_shift = {tap_in.data_in, st_r.ir_shift[`IR_WIDTH-1:1]};
            end
            dual_tap_pkg::UPDATE_IR: begin
                st_nxt.ir = st_r.ir_shift;
            end
            dual_tap_pkg::CAPTURE_DR: begin
                case (st_r.ir)
                    `IR_IDCODE:     st_nxt.dr_shift = ID_VALUE;
                    `IR_BSCAN:      st_nxt.dr_shift = {16'h0000, bscan_capture_in};
                    `IR_DEBUG_DATA: st_nxt.dr_shift = debug_capture_in;
                    default:        st_nxt.dr_shift = 32'h0000_0000;
                endcase
            end
            dual_tap_pkg::SHIFT_DR: begin
                // the serial input enters at the bit that matches the selected length
                st_nxt.dr_shift = st_r.dr_shift >> 1;
                st_nxt.dr_shift[len[4:0] - 5'd1] = tap_in.data_in;
            end
            dual_tap_pkg::UPDATE_DR: begin
                if (st_r.ir == `IR_BSCAN) begin
                    st_nxt.bscan_upd = st_r.dr_shift[`BSCAN_WIDTH-1:0];
                end
                if (st_r.ir == `IR_DEBUG_DATA) begin
                    st_nxt.debug_upd   = st_r.dr_shift;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            st_r <= '{state: dual_tap_pkg::TEST_LOGIC_RESET, ir: `IR_RESET_VALUE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // output changes on the falling edge so the prober samples it stable on the rise
    always_comb begin
        out_nxt = '0;
        if (st_r.state == dual_tap_pkg::SHIFT_IR) begin
            out_nxt.shift_out  = st_r.ir_shift[0];
            out_nxt.out_enable = 1'b1;
        end else if (st_r.state == dual_tap_pkg::SHIFT_DR) begin
            out_nxt.shift_out  = st_r.dr_shift[0];
            out_nxt.out_enable = 1'b1;
        end
    end

    always_ff @(negedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign tap_out                = out_r;
    assign bscan_update_out       = st_r.bscan_upd;
    assign debug_update_out       = st_r.debug_upd;
    assign debug_update_pulse_out = st_r.debug_pulse;

    AST_TDO_ONLY_SHIFT: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        out_r.out_enable |-> (st_r.state == dual_tap_pkg::SHIFT_IR
                           || st_r.state == dual_tap_pkg::SHIFT_DR))
        else $error("data out enabled outside a shift state");
    AST_FIVE_ONES_RESET: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        tap_in.mode_select [*5] |=> st_r.state == dual_tap_pkg::TEST_LOGIC_RESET)
        else $error("five high mode selects did not reach reset state");
    AST_IR_LOADS: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        st_r.state == dual_tap_pkg::UPDATE_IR |=> st_r.ir == $past(st_r.ir_shift))
        else $error("instruction not taken on update");
endmodule

// ==== hw/dual_tap_test_port.sv ====
`timescale 1ns/100ps
`include "dual_tap_map.svh"

// Notes on behaviour
// - Low test reset clears scan logic and both controllers at once, no clock needed.
// - Scan mode select drives the scan controller; debug mode select drives the debug one.
// - All shifting runs on the test clock, asynchronous to the core clock.
// - Serial data in feeds whichever controller is currently shifting.
// - Data out is driven only while a path shifts out, else released.
module dual_tap_test_port (
    input  wire logic                        core_clk_in,
    input  wire logic                        arst_n_in,
    input  wire logic                        test_clk_in,
    input  wire logic                        test_rst_n_in,
    input  wire logic                        scan_mode_select_in,
    input  wire logic                        debug_mode_select_in,
    input  wire logic                        test_data_in,
    output logic                             test_data_out,
    output logic                             test_data_oe_out,
    input  wire logic [`BSCAN_WIDTH-1:0]     pin_state_in,
    output logic [`BSCAN_WIDTH-1:0]          pin_drive_out,
    input  wire logic [`DEBUG_DR_WIDTH-1:0]  debug_status_in,
    output logic [`DEBUG_DR_WIDTH-1:0]       debug_command_out,
    output logic                             debug_command_valid_out
);
    dual_tap_pkg::tap_out_type scan_out;
    dual_tap_pkg::tap_out_type debug_out;
    logic [`BSCAN_WIDTH-1:0]    scan_upd;
    logic [`DEBUG_DR_WIDTH-1:0] debug_upd;
    logic                       debug_pulse;
    logic [`DEBUG_DR_WIDTH-1:0] debug_status_hold_r;
    logic                       toggle_r;

    // the unused controller idles in reset because its select is held high
    tap_controller #(.ID_VALUE(`IDCODE_VALUE)) u_scan_tap (
        .tck_in                 (test_clk_in),
        .trst_n_in              (test_rst_n_in),
        .tap_in                 ('{mode_select: scan_mode_select_in, data_in: test_data_in}),
        .bscan_capture_in       (pin_state_in),
        .debug_capture_in       (debug_status_hold_r),
        .tap_out                (scan_out),
        .bscan_update_out       (scan_upd),
        .debug_update_out       (),
        .debug_update_pulse_out ()
    );

    tap_controller #(.ID_VALUE(`IDCODE_VALUE ^ 32'h0000_0010)) u_debug_tap (
        .tck_in                 (test_clk_in),
        .trst_n_in              (test_rst_n_in),
        .tap_in                 ('{mode_select: debug_mode_select_in, data_in: test_data_in}),
        .bscan_capture_in       (pin_state_in),
        .debug_capture_in       (debug_status_hold_r),
        .tap_out                (debug_out),
        .bscan_update_out       (),
        .debug_update_out       (debug_upd),
        .debug_update_pulse_out (debug_pulse)
    );

    // status is sampled into the test clock domain; a multi-bit snapshot may tear,
    // acceptable for a debug status word that software re-reads
    always_ff @(posedge test_clk_in or negedge test_rst_n_in) begin
        if (!test_rst_n_in) begin
            debug_status_hold_r <= '0;
            toggle_r            <= 1'b0;
        end else begin
            debug_status_hold_r <= debug_status_in;
            if (debug_pulse) begin
                toggle_r <= ~toggle_r;
            end
        end
    end

    // scan path takes the pin when both shift; the prober must park one side
    assign test_data_out    = scan_out.out_enable ? scan_out.shift_out : debug_out.shift_out;
    assign test_data_oe_out = scan_out.out_enable | debug_out.out_enable;
    assign pin_drive_out    = scan_upd;

    typedef struct packed {
        logic [2:0]                 tog_sync;
        logic [`DEBUG_DR_WIDTH-1:0] cmd;
        logic                       cmd_valid;
    } core_state_type;

    core_state_type core_r;
    core_state_type core_nxt;

    always_comb begin
        core_nxt           = core_r;
        core_nxt.tog_sync  = {core_r.tog_sync[1:0], toggle_r};
        core_nxt.cmd_valid = core_r.tog_sync[2] ^ core_r.tog_sync[1];
        if (core_r.tog_sync[2] ^ core_r.tog_sync[1]) begin
            // word is stable: it changed a full sync delay before the toggle arrived
            core_nxt.cmd = debug_upd;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            core_r <= '0;
        end else begin
            core_r <= core_nxt;
        end
    end

    assign debug_command_out       = core_r.cmd;
    assign debug_command_valid_out = core_r.cmd_valid;

    AST_VALID_ONE_CYCLE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        debug_command_valid_out |=> !debug_command_valid_out)
        else $error("command valid held longer than one cycle");
    AST_OE_IDLE_AFTER_RESET: assert property (@(posedge test_clk_in)
        !test_rst_n_in |-> !test_data_oe_out)
        else $error("data out driven during test reset");
    AST_OE_SOURCES: assert property (@(negedge test_clk_in) disable iff (!test_rst_n_in)
        test_data_oe_out == (scan_out.out_enable | debug_out.out_enable))
        else $error("output enable does not follow shifting paths");
    AST_SCAN_PRIORITY: assert property (@(negedge test_clk_in) disable iff (!test_rst_n_in)
        scan_out.out_enable |-> test_data_out == scan_out.shift_out)
        else $error("scan path not on data out");
    AST_PARK_SCAN: assert property (@(posedge test_clk_in) disable iff (!test_rst_n_in)
        scan_mode_select_in [*6] |-> !scan_out.out_enable)
        else $error("parked scan controller drives data out");
endmodule

// ==== bench/tap_prober.sv ====
`timescale 1ns/100ps
module tap_prober (
    output logic      tck_out,
    output logic      trst_n_out,
    output logic      scan_sel_out,
    output logic      debug_sel_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    logic use_debug;
    initial begin
        tck_out = 1'b0;
        trst_n_out = 1'b0;
        scan_sel_out = 1'b1;
        debug_sel_out = 1'b1;
        tdi_out = 1'b0;
        use_debug = 1'b0;
    end
    task automatic hold_reset(input logic v);
        trst_n_out = v;
    endtask
    // the idle controller keeps its select high so it stays parked
    task automatic cycle(input logic tms, input logic tdi, output logic tdo);
        if (use_debug) debug_sel_out <= tms;
        else scan_sel_out <= tms;
        tdi_out <= tdi;
        #6;
        tdo = tdo_in;
        tck_out = 1'b1;
        #6;
        tck_out = 1'b0;
    endtask
    task automatic reset_tap(input logic dbg);
        logic t;
        use_debug = dbg;
        repeat (5) cycle(1'b1, 1'b0, t);
        cycle(1'b0, 1'b0, t);
    endtask
    // clock stands still outside cycle calls; tdi flips so a stale level is not trusted
    task automatic frame(input logic dbg, input logic ir, input int n,
                         input logic [31:0] din, output logic [31:0] dout);
        logic t;
        use_debug = dbg;
        dout = '0;
        cycle(1'b1, 1'b0, t);
        if (ir) cycle(1'b1, 1'b0, t);
        cycle(1'b0, 1'b0, t);
        cycle(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            cycle(i == n - 1, din[i], t);
            dout[i] = t;
        end
        cycle(1'b1, 1'b0, t);
        cycle(1'b0, 1'b0, t);
        scan_sel_out <= 1'b1;
        debug_sel_out <= 1'b1;
        tdi_out <= ~tdi_out;
    endtask
endmodule

// ==== bench/test_dual_tap_test_port.sv ====
`timescale 1ns/100ps
`include "dual_tap_map.svh"
module test_dual_tap_test_port;
    logic                        core_clk_in, arst_n_in, tck, trst_n, ssel, dsel, tdi;
    logic                        test_data_out, test_data_oe_out, debug_command_valid_out;
    logic [`BSCAN_WIDTH-1:0]     pin_state_in, pin_drive_out;
    logic [`DEBUG_DR_WIDTH-1:0]  debug_status_in, debug_command_out;
    logic [31:0]                 d;
    wire                         tdo_line = test_data_oe_out ? test_data_out : 1'bz;
    int                          err_total = 0;
    int                          n_compared = 0;

    dual_tap_test_port dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .test_clk_in(tck), .test_rst_n_in(trst_n), .scan_mode_select_in(ssel),
        .debug_mode_select_in(dsel), .test_data_in(tdi), .test_data_out(test_data_out),
        .test_data_oe_out(test_data_oe_out), .pin_state_in(pin_state_in),
        .pin_drive_out(pin_drive_out), .debug_status_in(debug_status_in),
        .debug_command_out(debug_command_out),
        .debug_command_valid_out(debug_command_valid_out));
    tap_prober prober (.tck_out(tck), .trst_n_out(trst_n), .scan_sel_out(ssel),
        .debug_sel_out(dsel), .tdi_out(tdi), .tdo_in(tdo_line));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic run_idcode;
        prober.reset_tap(1'b0);
        prober.frame(1'b0, 1'b0, 32, 32'h0, d);
        check(d, `IDCODE_VALUE);
        check(test_data_oe_out, 1'b0);
        prober.reset_tap(1'b1);
        prober.frame(1'b1, 1'b0, 32, 32'h0, d);
        check(d, `IDCODE_VALUE ^ 32'h10);
    endtask
    task automatic run_bypass;
        prober.reset_tap(1'b0);
        prober.frame(1'b0, 1'b1, 4, 32'hf, d);
        check(d[3:0], 4'h1);
        prober.frame(1'b0, 1'b0, 8, 32'hb5, d);
        check(d[7:0], 8'h6a);
    endtask
    task automatic run_scan;
        @(posedge core_clk_in);
        pin_state_in <= 16'hc3a5;
        prober.reset_tap(1'b0);
        prober.frame(1'b0, 1'b1, 4, 32'h2, d);
        prober.frame(1'b0, 1'b0, 16, 32'h5a0f, d);
        check(d[15:0], 16'hc3a5);
        check(pin_drive_out, 16'h5a0f);
    endtask
    // the command crosses into the core domain a few core cycles after update
    task automatic run_debug;
        logic hit;
        hit = 1'b0;
        @(posedge core_clk_in);
        debug_status_in <= 32'h9e37_79b9;
        prober.reset_tap(1'b1);
        prober.frame(1'b1, 1'b1, 4, 32'h8, d);
        prober.frame(1'b1, 1'b0, 32, 32'h0bad_f00d, d);
        check(d, 32'h9e37_79b9);
        for (int i = 0; i < 60 && !hit; i++) begin
            @(posedge core_clk_in);
            #1;
            if (debug_command_valid_out === 1'b1) hit = 1'b1;
        end
        check(hit, 1'b1);
        check(debug_command_out, 32'h0bad_f00d);
        @(posedge core_clk_in);
        #1;
        check(debug_command_valid_out, 1'b0);
    endtask
    task automatic run_reset;
        logic t;
        prober.reset_tap(1'b0);
        prober.frame(1'b0, 1'b1, 4, 32'hf, d);
        prober.cycle(1'b1, 1'b0, t);
        prober.cycle(1'b0, 1'b0, t);
        prober.cycle(1'b0, 1'b0, t);
        #1;
        check(test_data_oe_out, 1'b1);
        prober.hold_reset(1'b0);
        #1;
        check(test_data_oe_out, 1'b0);
        check(test_data_out, 1'b0);
        prober.hold_reset(1'b1);
        prober.cycle(1'b0, 1'b0, t);
        prober.frame(1'b0, 1'b0, 32, 32'h0, d);
        check(d, `IDCODE_VALUE);
    endtask

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        arst_n_in = 1'b0;
        pin_state_in = '0;
        debug_status_in = '0;
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        @(posedge core_clk_in);
        prober.hold_reset(1'b1);
        run_idcode();
        run_bypass();
        run_scan();
        run_debug();
        run_reset();
        tally_and_finish();
    end
endmodule
